// *** rtl/fpsup_pkg.sv ***
/*
 Constants, types and helpers for the power-fail and retry supervisor.
 Assumes a 40 MHz pclk and an APB master with 32-bit data.
*/
// Notes on behaviour
// - continuation modes ramp back to set frequency when supply returns mid-decel.
// - auto continuation decelerates holding bus constant, re-accelerates on recovery.
// - auto modes ignore subtraction and fixed deceleration slope settings.
// - after a power-fail stop, no restart until start command drops.
// - status flag high during power-fail decel and the stop after it.
// - status flag also high whenever undervoltage is seen.
// - terminal selector 46 routes flag, 146 routes it inverted.
// - stop-method selection ignored during power-fail deceleration.
// - regenerative select 2 disables power-fail deceleration.
// - negative start frequency clamps to zero with DC injection, no ramp.
// - no power-fail behaviour when stopped or tripped.
// - power-fail modes suppress undervoltage, instant-fail and phase-loss trips.
// - eligible trip waits retry delay, resets fault, restarts at start frequency.
// - limit 1..10 hides fault output; 101..110 keeps it, limit minus 100.
// - failures beyond the limit raise retry-excess fault and stay tripped.
// - run fault-free over four delays counts a success, clears failures.
// - success count readable; writing zero clears it.
// - retry-active flag during retry; selector 64 true, 164 inverted.
// - fault-select 0..5 picks retry-eligible fault groups.
// - fault record keeps only the first fault of a retry sequence.
// - retry reset keeps thermal data; only power-on reset clears it.
// - ineligible fault during retry wait abandons retry, stays tripped.
package fpsup_pkg;

    localparam int CLK_PERIOD_NS = 25;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
    localparam int DELAY_UNIT_MS = 100;
    localparam int SUCCESS_FACTOR = 4;

    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RETRY = 8'h04;
    localparam logic [7:0] A_DECEL = 8'h08;
    localparam logic [7:0] A_SWITCH = 8'h0c;
    localparam logic [7:0] A_OUTSEL = 8'h10;
    localparam logic [7:0] A_STATUS = 8'h14;
    localparam logic [7:0] A_SUCCESS = 8'h18;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_REGEN_LSB = 8;
    localparam int CTRL_STOP_BIT = 16;
    localparam int RETRY_SEL_LSB = 0;
    localparam int RETRY_LIM_LSB = 8;
    localparam int RETRY_DLY_LSB = 16;
    localparam int DECEL_SUB_LSB = 0;
    localparam int DECEL_ACC_LSB = 8;
    localparam int DECEL_DEC1_LSB = 16;
    localparam int DECEL_DEC2_LSB = 24;
    localparam int OUTSEL1_LSB = 8;
    localparam int STAT_FAILS_LSB = 8;
    localparam int STAT_FIRST_LSB = 16;
    localparam int STAT_LAST_LSB = 24;

    localparam logic [7:0] RST_DELAY = 8'h0a;
    localparam logic [7:0] RST_SUB = 8'h1e;
    localparam logic [7:0] RST_STEP = 8'h01;
    localparam logic [15:0] RST_SWITCH = 16'h0258;

    localparam logic [4:0] MODE_COAST = 5'h00;
    localparam logic [4:0] MODE_CONT = 5'h02;
    localparam logic [4:0] MODE_AUTO = 5'h15;
    localparam logic [4:0] MODE_AUTO_CONT = 5'h16;
    localparam logic [1:0] REGEN_EXT = 2'h2;
    localparam logic [7:0] TERM_PF = 8'h2e;
    localparam logic [7:0] TERM_PF_INV = 8'h92;
    localparam logic [7:0] TERM_RETRY = 8'h40;
    localparam logic [7:0] TERM_RETRY_INV = 8'ha4;
    localparam logic [6:0] LIMIT_KEEP_BASE = 7'h64;
    localparam logic [6:0] LIMIT_MAX = 7'h0a;
    localparam logic [7:0] DELAY_MAX = 8'h64;
    localparam logic [15:0] START_FREQ = 16'h0005;
    localparam logic [7:0] AUTO_STEP = 8'h01;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_RUN = 3'h1, ST_PFDEC = 3'h3,
        ST_PFSTOP = 3'h2, ST_RWAIT = 3'h5, ST_TRIP = 3'h4
    } fpsup_state_t;

    typedef enum logic [4:0] {
        FLT_NONE = 5'h00, FLT_OC_ACCEL, FLT_OC_CONST, FLT_OC_DECEL,
        FLT_OV_ACCEL, FLT_OV_CONST, FLT_OV_DECEL, FLT_MOTOR_THERM,
        FLT_TRANS_THERM, FLT_INST_PF, FLT_UNDERVOLT, FLT_BRAKE_TR,
        FLT_GROUND, FLT_EXT_THERM, FLT_STALL, FLT_OPT_CONN, FLT_OPT1,
        FLT_OPT2, FLT_PARAM_STORE, FLT_THERMISTOR, FLT_OUT_CURR,
        FLT_COMM, FLT_PHASE_LOSS, FLT_PID, FLT_PRECHARGE,
        FLT_ANALOG_LOSS, FLT_RETRY_EXCESS
    } fpsup_fault_t;

    function automatic logic fpsup_eligible(input logic [2:0] sel, input fpsup_fault_t f);
        logic oc;
        logic ov;
        logic th;
        oc = f inside {FLT_OC_ACCEL, FLT_OC_CONST, FLT_OC_DECEL};
        ov = f inside {FLT_OV_ACCEL, FLT_OV_CONST, FLT_OV_DECEL};
        th = f inside {FLT_MOTOR_THERM, FLT_TRANS_THERM, FLT_EXT_THERM, FLT_THERMISTOR};
        case (sel)
            3'h0: fpsup_eligible = 1'b1;
            3'h1: fpsup_eligible = oc;
            3'h2: fpsup_eligible = ov;
            3'h3: fpsup_eligible = oc | ov;
            3'h4: fpsup_eligible = ~th;
            3'h5: fpsup_eligible = f inside {FLT_OC_ACCEL, FLT_OC_DECEL};
            default: fpsup_eligible = 1'b0;
        endcase
        if (f == FLT_NONE || f == FLT_RETRY_EXCESS) begin
            fpsup_eligible = 1'b0;
        end
    endfunction : fpsup_eligible

endpackage : fpsup_pkg

// *** rtl/fpsup_top.sv ***
/*
 Power-fail deceleration and automatic fault retry supervisor with APB registers.
 Assumes supply monitor and start pins are asynchronous; fault reports,
 set frequency and fault clear come from logic on pclk.
*/
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module fpsup_top import fpsup_pkg::*; #(
    parameter int TICK_CYC = TICK_CYCLES
) (
    // clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // supply and start pins
    input wire logic undervoltage,
    input wire logic power_fail,
    input wire logic phase_loss,
    input wire logic bus_high,
    input wire logic start_cmd,
    // drive core
    input wire logic [15:0] set_freq,
    input wire logic fault_valid,
    input wire logic [4:0] fault_code,
    input wire logic fault_clear,
    // drive outputs
    output logic [15:0] out_freq,
    output logic run,
    output logic dc_inject,
    output logic fault_output,
    output logic fault_reset,
    output logic thermal_clear,
    output logic trip_suppress,
    output logic [4:0] fault_record,
    // status and terminals
    output logic power_fail_decel_flag,
    output logic retry_active_flag,
    output logic [1:0] term_out
);

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        fpsup_state_t st;
        logic [15:0] pre;
        logic [15:0] tmr;
        logic [15:0] freq;
        logic [15:0] succ;
        logic [15:0] sw;
        logic brake;
        logic prob;
        logic por;
        logic rstp;
        logic [3:0] fails;
        logic [4:0] first;
        logic [4:0] last;
        logic [4:0] mode;
        logic [1:0] regen;
        logic stopm;
        logic [2:0] rsel;
        logic [6:0] lim;
        logic [7:0] dly;
        logic [7:0] sub;
        logic [7:0] acc;
        logic [7:0] dec1;
        logic [7:0] dec2;
        logic [7:0] sel0;
        logic [7:0] sel1;
        logic [31:0] rd;
    } fpsup_regs_t;

    fpsup_regs_t r, next_r;

    logic uv, pf_any, bus_ok, start, tick, pf_en, auto_m, cont_m;
    logic keep_fault, elig, fault_take, wr, mapped, sub_neg;
    logic [3:0] lim_eff;
    logic [15:0] dly_ms, win, rampd, decd, subd, ramp_run;
    logic [16:0] f_up;
    logic [7:0] dstep;
    logic [31:0] rdmux;

    // ------------------------------------------------------------
    // decode of pins and settings
    // ------------------------------------------------------------
    assign uv = r.s2[0];
    assign pf_any = |r.s2[2:0];
    assign bus_ok = r.s2[3];
    assign start = r.s2[4];
    assign tick = r.pre == 16'(TICK_CYC - 1);

    assign pf_en = r.mode != MODE_COAST && r.regen != REGEN_EXT;
    assign auto_m = r.mode == MODE_AUTO || r.mode == MODE_AUTO_CONT;
    assign cont_m = r.mode == MODE_CONT || r.mode == MODE_AUTO_CONT;

    assign lim_eff = (r.lim > LIMIT_KEEP_BASE && r.lim <= LIMIT_KEEP_BASE + LIMIT_MAX) ?
                     4'(r.lim - LIMIT_KEEP_BASE) : (r.lim <= LIMIT_MAX ? 4'(r.lim) : 4'h0);
    assign keep_fault = r.lim > LIMIT_KEEP_BASE;
    assign elig = fpsup_eligible(r.rsel, fpsup_fault_t'(fault_code));
    assign fault_take = fault_valid & ~(pf_en & (fault_code inside
                        {FLT_UNDERVOLT, FLT_INST_PF, FLT_PHASE_LOSS}));

    assign dly_ms = 16'(r.dly * DELAY_UNIT_MS);
    assign win = 16'(dly_ms * SUCCESS_FACTOR);

    // ------------------------------------------------------------
    // frequency arithmetic, all clamped at zero
    // ------------------------------------------------------------
    assign f_up = {1'b0, r.freq} + {9'h0, r.acc};
    assign rampd = r.freq > {8'h0, r.acc} ? r.freq - {8'h0, r.acc} : 16'h0;
    assign ramp_run = r.freq < set_freq ?
                      (f_up > {1'b0, set_freq} ? set_freq : f_up[15:0]) :
                      (rampd < set_freq ? set_freq : rampd);
    // bus regulation in auto modes: hold while the bus is high, else slow down; other modes use dec1 above sw, dec2 below
    assign dstep = auto_m ? (bus_ok ? 8'h00 : AUTO_STEP) :
                   (r.freq > r.sw ? r.dec1 : r.dec2);
    assign decd = r.freq > {8'h0, dstep} ? r.freq - {8'h0, dstep} : 16'h0;
    assign sub_neg = r.freq < {8'h0, r.sub};
    assign subd = sub_neg ? 16'h0 : r.freq - {8'h0, r.sub};

    // ------------------------------------------------------------
    // apb slave: no wait states unless ce is low
    // ------------------------------------------------------------
    assign wr = psel & penable & pwrite & ce;
    assign mapped = paddr inside {A_CTRL, A_RETRY, A_DECEL, A_SWITCH, A_OUTSEL,
                                  A_STATUS, A_SUCCESS};
    assign pready = ce;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = r.rd;

    always_comb begin
        case (paddr)
            A_CTRL: rdmux = {15'h0, r.stopm, 6'h0, r.regen, 3'h0, r.mode};
            A_RETRY: rdmux = {8'h0, r.dly, 1'b0, r.lim, 5'h0, r.rsel};
            A_DECEL: rdmux = {r.dec2, r.dec1, r.acc, r.sub};
            A_SWITCH: rdmux = {16'h0, r.sw};
            A_OUTSEL: rdmux = {16'h0, r.sel1, r.sel0};
            A_STATUS: rdmux = {3'h0, r.last, 3'h0, r.first, 4'h0, r.fails, 5'h0, r.st};
            A_SUCCESS: rdmux = {16'h0, r.succ};
            default: rdmux = 32'h0;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.s1 = {start_cmd, bus_high, phase_loss, power_fail, undervoltage};
        next_r.s2 = r.s1;
        next_r.por = 1'b0;
        next_r.rstp = 1'b0;
        next_r.pre = tick ? 16'h0 : r.pre + 16'h1;
        if (psel) begin
            next_r.rd = rdmux;
        end
        if (wr) begin
            case (paddr)
                A_CTRL: begin
                    next_r.mode = pwdata[CTRL_MODE_LSB +: 5];
                    next_r.regen = pwdata[CTRL_REGEN_LSB +: 2];
                    next_r.stopm = pwdata[CTRL_STOP_BIT];
                end
                A_RETRY: begin
                    next_r.rsel = pwdata[RETRY_SEL_LSB +: 3];
                    next_r.lim = pwdata[RETRY_LIM_LSB +: 7];
                    next_r.dly = pwdata[RETRY_DLY_LSB +: 8] > DELAY_MAX ?
                                 DELAY_MAX : pwdata[RETRY_DLY_LSB +: 8];
                end
                A_DECEL: begin
                    next_r.sub = pwdata[DECEL_SUB_LSB +: 8];
                    next_r.acc = pwdata[DECEL_ACC_LSB +: 8];
                    next_r.dec1 = pwdata[DECEL_DEC1_LSB +: 8];
                    next_r.dec2 = pwdata[DECEL_DEC2_LSB +: 8];
                end
                A_SWITCH: next_r.sw = pwdata[15:0];
                A_OUTSEL: begin
                    next_r.sel0 = pwdata[7:0];
                    next_r.sel1 = pwdata[OUTSEL1_LSB +: 8];
                end
                A_SUCCESS: begin
                    if (pwdata == 32'h0) begin
                        next_r.succ = 16'h0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (fault_take && (r.st == ST_RUN || r.st == ST_PFDEC)) begin
            // only the opening fault of a sequence is kept
            if (r.fails == 4'h0) begin
                next_r.first = fault_code;
            end
            next_r.last = fault_code;
            next_r.freq = 16'h0;
            next_r.brake = 1'b0;
            next_r.prob = 1'b0;
            next_r.tmr = 16'h0;
            if (lim_eff != 4'h0 && elig) begin
                if (r.fails >= lim_eff) begin
                    next_r.st = ST_TRIP;
                    next_r.last = FLT_RETRY_EXCESS;
                end else begin
                    next_r.st = ST_RWAIT;
                    next_r.fails = r.fails + 4'h1;
                end
            end else begin
                next_r.st = ST_TRIP;
            end
        end else begin
            case (r.st)
                ST_IDLE: begin
                    next_r.brake = 1'b0;
                    if (start) begin
                        next_r.st = ST_RUN;
                    end else if (tick) begin
                        next_r.freq = rampd;
                    end
                end
                ST_RUN: begin
                    if (pf_any && pf_en) begin
                        next_r.st = ST_PFDEC;
                        next_r.brake = ~auto_m & sub_neg;
                        next_r.freq = auto_m ? r.freq : subd;
                    end else if (!start) begin
                        next_r.st = ST_IDLE;
                        if (r.stopm) begin
                            next_r.freq = 16'h0;
                        end
                    end else if (tick) begin
                        next_r.freq = ramp_run;
                        if (r.prob) begin
                            next_r.tmr = r.tmr + 16'h1;
                            if (r.tmr > win) begin
                                next_r.succ = next_r.succ + 16'h1;
                                next_r.fails = 4'h0;
                                next_r.prob = 1'b0;
                            end
                        end
                    end
                end
                ST_PFDEC: begin
                    // start command and stop method are both ignored here
                    if (!pf_any && cont_m && !r.brake) begin
                        next_r.st = ST_RUN;
                    end else if (r.freq == 16'h0) begin
                        next_r.st = ST_PFSTOP;
                    end else if (tick) begin
                        next_r.freq = decd;
                    end
                end
                ST_PFSTOP: begin
                    next_r.freq = 16'h0;
                    if (!start) begin
                        next_r.st = ST_IDLE;
                        next_r.brake = 1'b0;
                    end
                end
                ST_RWAIT: begin
                    if (fault_take && !elig) begin
                        next_r.st = ST_TRIP;
                        next_r.last = fault_code;
                    end else if (r.tmr >= dly_ms) begin
                        next_r.st = ST_RUN;
                        next_r.freq = START_FREQ;
                        next_r.rstp = 1'b1;
                        next_r.prob = 1'b1;
                        next_r.tmr = 16'h0;
                    end else if (tick) begin
                        next_r.tmr = r.tmr + 16'h1;
                    end
                end
                ST_TRIP: begin
                    if (fault_clear) begin
                        next_r.st = ST_IDLE;
                        next_r.fails = 4'h0;
                    end
                end
                default: next_r.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.por <= 1'b1;
            r.dly <= RST_DELAY;
            r.sub <= RST_SUB;
            r.acc <= RST_STEP;
            r.dec1 <= RST_STEP;
            r.dec2 <= RST_STEP;
            r.sw <= RST_SWITCH;
        end else if (ce) begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    function automatic logic term_map(input logic [7:0] sel, input logic pf, input logic rt);
        case (sel)
            TERM_PF: term_map = pf;
            TERM_PF_INV: term_map = ~pf;
            TERM_RETRY: term_map = rt;
            TERM_RETRY_INV: term_map = ~rt;
            default: term_map = 1'b0;
        endcase
    endfunction : term_map

    assign power_fail_decel_flag = uv | r.st == ST_PFDEC | r.st == ST_PFSTOP;
    assign retry_active_flag = r.st == ST_RWAIT;
    assign term_out[0] = term_map(r.sel0, power_fail_decel_flag, retry_active_flag);
    assign term_out[1] = term_map(r.sel1, power_fail_decel_flag, retry_active_flag);
    assign out_freq = r.freq;
    assign run = r.st == ST_RUN || r.st == ST_PFDEC;
    assign dc_inject = r.brake & (r.st == ST_PFDEC || r.st == ST_PFSTOP);
    assign fault_output = r.st == ST_TRIP || (r.st == ST_RWAIT && keep_fault);
    assign fault_reset = r.rstp;
    // thermal data cleared by power-on only, never by a retry
    assign thermal_clear = r.por;
    assign trip_suppress = pf_en;
    assign fault_record = r.first;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_resume;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.st == ST_PFDEC && !pf_any && cont_m && !r.brake && !fault_valid)
        |=> r.st == ST_RUN;
    endproperty
    a_resume: assert property (p_resume) else $error("no resume");
    property p_auto_hold;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.st == ST_PFDEC && auto_m && bus_ok && pf_any && !fault_valid && tick)
        |=> $stable(r.freq);
    endproperty
    a_auto_hold: assert property (p_auto_hold) else $error("auto decel moved");
    property p_no_restart;
        @(posedge pclk) disable iff (!presetn)
        (r.st == ST_PFSTOP && start) |=> r.st != ST_RUN;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("restart");
    property p_uv_flag;
        @(posedge pclk) disable iff (!presetn)
        (ce && undervoltage) [*3] |-> power_fail_decel_flag;
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("flag low");
    property p_regen_off;
        @(posedge pclk) disable iff (!presetn)
        (r.regen == REGEN_EXT && r.st == ST_RUN) |=> r.st != ST_PFDEC;
    endproperty
    a_regen_off: assert property (p_regen_off) else $error("decel");
    property p_clamp;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.st == ST_RUN && !fault_valid && pf_any && pf_en && !auto_m && sub_neg)
        |=> (r.freq == 16'h0 && dc_inject);
    endproperty
    a_clamp: assert property (p_clamp) else $error("no clamp");
    property p_suppress;
        @(posedge pclk) disable iff (!presetn)
        (ce && pf_en && fault_valid && fault_code == FLT_UNDERVOLT && r.st == ST_RUN)
        |=> r.st != ST_TRIP;
    endproperty
    a_suppress: assert property (p_suppress) else $error("uv trip");
    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        $rose(r.rstp) |-> (r.st == ST_RUN && r.freq == START_FREQ && !thermal_clear);
    endproperty
    a_restart: assert property (p_restart) else $error("bad restart");
    property p_excess;
        @(posedge pclk) disable iff (!presetn)
        (ce && fault_take && elig && lim_eff != 4'h0 && r.fails >= lim_eff && r.st == ST_RUN)
        |=> (r.st == ST_TRIP && r.last == FLT_RETRY_EXCESS);
    endproperty
    a_excess: assert property (p_excess) else $error("no excess");
    property p_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == A_SUCCESS && pwdata == 32'h0) |=> r.succ <= 16'h1;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");
    property p_abandon;
        @(posedge pclk) disable iff (!presetn)
        (ce && r.st == ST_RWAIT && fault_take && !elig) |=> r.st == ST_TRIP;
    endproperty
    a_abandon: assert property (p_abandon) else $error("retry kept");

endmodule : fpsup_top

// *** bench/fpsup_drive_model.sv ***
/*
 Far-side model: drive core fault reports, start command and set frequency.
 Assumes its tasks are called from the pclk domain by the bench.
*/
`timescale 1ns/1ps
module fpsup_drive_model import fpsup_pkg::*; (
    // clock
    input wire logic pclk,
    // towards the supervisor
    output logic start_cmd,
    output logic [15:0] set_freq,
    output logic fault_valid,
    output logic [4:0] fault_code
);
    initial begin
        start_cmd = 1'b0;
        set_freq = 16'h0040;
        fault_valid = 1'b0;
        fault_code = 5'h00;
    end

    // leaves the inverted code behind on purpose
    task automatic report(input fpsup_fault_t f);
        @(posedge pclk);
        fault_valid <= 1'b1;
        fault_code <= f;
        @(posedge pclk);
        fault_valid <= 1'b0;
        fault_code <= ~f;
    endtask : report
endmodule : fpsup_drive_model

// *** bench/fpsup_top_tb.sv ***
/*
 Self-checking bench for the supervisor: APB tasks plus scripted sequences.
 Assumes the package constants and a shortened ms tick of 4 cycles.
*/
`timescale 1ns/1ps
module fpsup_top_tb import fpsup_pkg::*;;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, slv_err, fault_clear = 1'b0;
    logic undervoltage = 1'b0, power_fail = 1'b0, bus_high = 1'b0;
    logic start_cmd, fault_valid, run, dc_inject, fault_output, fault_reset, thermal_clear;
    logic trip_suppress, power_fail_decel_flag, retry_active_flag;
    logic [15:0] set_freq, out_freq;
    logic [4:0] fault_code, fault_record;
    logic [1:0] term_out;
    int err_total = 0, tests_run = 0, n;

    fpsup_top #(.TICK_CYC(4)) u_fpsup_top (.pclk(pclk), .presetn(presetn), .ce(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .undervoltage(undervoltage),
        .power_fail(power_fail), .phase_loss(1'b0), .bus_high(bus_high), .start_cmd(start_cmd),
        .set_freq(set_freq), .fault_valid(fault_valid), .fault_code(fault_code),
        .fault_clear(fault_clear), .out_freq(out_freq), .run(run), .dc_inject(dc_inject),
        .fault_output(fault_output), .fault_reset(fault_reset),
        .thermal_clear(thermal_clear), .trip_suppress(trip_suppress),
        .fault_record(fault_record), .power_fail_decel_flag(power_fail_decel_flag),
        .retry_active_flag(retry_active_flag), .term_out(term_out));
    fpsup_drive_model u_fpsup_drive_model (.pclk(pclk), .start_cmd(start_cmd),
        .set_freq(set_freq), .fault_valid(fault_valid), .fault_code(fault_code));

    initial begin
        forever #12.5 pclk = ~pclk;
    end

    task automatic test_done();
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : ck

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic cyc(input int c);
        repeat (c) @(posedge pclk);
    endtask : cyc

    task automatic wait_restart();
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (fault_reset !== 1'b1 && n < 800);
    endtask : wait_restart

    initial begin
        cyc(12);
        presetn <= 1'b1;
        apb(0, A_RETRY, 0);
        ck("retry reset", 32'h000a0000, rdata);
        apb(0, 8'h40, 0);
        ck("unmapped err", 1, {31'h0, slv_err});
        // retry success and counter
        apb(1, A_OUTSEL, {16'h0, TERM_PF, TERM_RETRY});
        apb(1, A_RETRY, 32'h00010200);
        u_fpsup_drive_model.start_cmd <= 1'b1;
        cyc(300);
        u_fpsup_drive_model.report(FLT_OC_ACCEL);
        @(negedge pclk);
        ck("retry flags", 32'h9, {retry_active_flag, fault_output, term_out});
        wait_restart();
        ck("delay ok", 1, {31'h0, n > 390 && n < 410});
        ck("restart freq", {16'h0, START_FREQ}, {16'h0, out_freq});
        ck("thermal kept", 0, {31'h0, thermal_clear});
        cyc(1700);
        apb(0, A_SUCCESS, 0);
        ck("success", 1, rdata);
        apb(1, A_SUCCESS, 5);
        apb(0, A_SUCCESS, 0);
        ck("success kept", 1, rdata);
        apb(1, A_SUCCESS, 0);
        apb(0, A_SUCCESS, 0);
        ck("success clr", 0, rdata);
        // limit 101: one retry, then excess
        apb(1, A_RETRY, 32'h00016501);
        u_fpsup_drive_model.report(FLT_OC_ACCEL);
        @(negedge pclk);
        ck("fault shown", 1, {31'h0, fault_output});
        wait_restart();
        cyc(20);
        u_fpsup_drive_model.report(FLT_OC_CONST);
        apb(0, A_STATUS, 0);
        ck("excess", {8'h1a, 8'h01, 16'h0004}, rdata & 32'hff1f0007);
        ck("record", {27'h0, FLT_OC_ACCEL}, {27'h0, fault_record});
        ck("retry drop", 0, {31'h0, retry_active_flag});
        // ineligible fault while waiting
        fault_clear <= 1'b1;
        cyc(1);
        fault_clear <= 1'b0;
        apb(1, A_RETRY, 32'h00016e01);
        cyc(300);
        u_fpsup_drive_model.report(FLT_OC_DECEL);
        u_fpsup_drive_model.report(FLT_OV_CONST);
        cyc(2);
        ck("abandon", 32'h1, {30'h0, retry_active_flag, fault_output});
        ck("first kept", {27'h0, FLT_OC_DECEL}, {27'h0, fault_record});
        fault_clear <= 1'b1;
        cyc(1);
        fault_clear <= 1'b0;
        // power failure modes and undervoltage
        apb(1, A_CTRL, {27'h0, MODE_CONT});
        cyc(300);
        power_fail <= 1'b1;
        cyc(20);
        ck("pf decel", 32'h7, {29'h0, run, power_fail_decel_flag, term_out[1]});
        ck("suppress", 1, {31'h0, trip_suppress});
        power_fail <= 1'b0;
        cyc(300);
        ck("resume", {16'h1, 16'h0040}, {15'h0, run, out_freq});
        apb(1, A_DECEL, 32'h010101ff);
        apb(1, A_CTRL, 32'h00000001);
        power_fail <= 1'b1;
        cyc(400);
        power_fail <= 1'b0;
        cyc(20);
        ck("pf stop", 32'h3, {29'h0, run, power_fail_decel_flag, dc_inject});
        u_fpsup_drive_model.start_cmd <= 1'b0;
        cyc(6);
        ck("pf cleared", 0, {31'h0, power_fail_decel_flag});
        u_fpsup_drive_model.start_cmd <= 1'b1;
        apb(1, A_CTRL, 32'h00000201);
        cyc(300);
        power_fail <= 1'b1;
        cyc(20);
        ck("regen ext", 32'h2, {30'h0, run, power_fail_decel_flag | trip_suppress});
        bus_high <= 1'b1;
        apb(1, A_CTRL, {27'h0, MODE_AUTO_CONT});
        cyc(20);
        ck("auto hold", {16'h1, 16'h0040}, {15'h0, run, out_freq});
        power_fail <= 1'b0;
        u_fpsup_drive_model.start_cmd <= 1'b0;
        cyc(300);
        undervoltage <= 1'b1;
        cyc(6);
        ck("uv idle", 32'h1, {30'h0, run, power_fail_decel_flag});
        test_done();
    end

    initial begin
        cyc(20000);
        err_total++;
        test_done();
    end
endmodule : fpsup_top_tb
